// ---- lpm_pkg.sv ----
// Function
// (RULE1) In deep idle or sleep, only the time base timer keeps its clock.
// (RULE2) Memory, CPU registers, status word and port latches held unchanged.
// (RULE3) Resume address is two bytes past the mode start instruction.
// (RULE4) Software disables peripherals such as timer counters before entry.
// (RULE5) Writing 1 to the timing generator stop bit enters deep idle/sleep.
// (RULE6) Wake term 0: resume at next instruction, no interrupt.
// (RULE7) Wake term 1: leave mode, then service time base interrupt.
// (RULE8) On release hardware clears stop bit and restores previous run mode.
// (RULE9) Time base enable set at entry sets the time base interrupt latch.
// (RULE10) Entry and exit happen regardless of the time base enable bit.
// (RULE11) Reset pin low ends low-power or slow mode; restart single clock.
// (RULE12) Synchronised wake may come sooner than one source clock period.
// (RULE13) Pending watchdog interrupt at request: service it, do not enter.
// (RULE14) Fast to slow: select low clock (bit 5), then clear bit 7.
// (RULE15) Software waits for low oscillator (bit 6) to stabilise first.
// (RULE16) Fast oscillator may run in slow mode; off before stop mode.
// (RULE17) Slow to fast: enable fast oscillator, warm up, clear select bit.
// (RULE18) After select cleared, run on low clock until clocks synchronised.
package lpm_pkg;
  localparam int ADDR_W = 2;
  localparam int DATA_W = 8;
  localparam logic [1:0] SYS_CTRL_TWO_OFS = 2'h0;
  localparam logic [1:0] TB_CTRL_OFS = 2'h1;
  localparam logic [1:0] STATUS_OFS = 2'h2;
  localparam logic [1:0] IRQ_CTRL_OFS = 2'h3;
  // system_control_two fields
  localparam int HIGH_OSC_EN_BIT = 7;
  localparam int LOW_OSC_EN_BIT = 6;
  localparam int SYS_CLK_SEL_BIT = 5;
  localparam int STOP_BIT = 2;
  // time_base_control fields
  localparam int TB_EN_BIT = 3;
  localparam int TB_SEL_LSB = 0;
  localparam int TB_SEL_W = 3;
  // irq control fields
  localparam int MIE_BIT = 0;
  localparam int TB_IE_BIT = 1;
  localparam int TB_LATCH_BIT = 2;
  // reset values
  localparam logic [7:0] SYS_CTRL_TWO_RST = 8'h80;
  localparam logic [7:0] TB_CTRL_RST = 8'h00;
  localparam logic [7:0] IRQ_CTRL_RST = 8'h00;
  localparam int PC_W = 16;
  localparam logic [15:0] PC_STEP = 16'h0002;
  localparam int SYNC_TICKS = 2;
  typedef enum logic [1:0] {
    SINGLE_CLOCK_RUN,
    DUAL_CLOCK_FAST_RUN,
    SLOW_RUN_FAST_OSC_ON,
    SLOW_RUN_FAST_OSC_OFF
  } run_mode_t;
endpackage : lpm_pkg

// ---- clk_sw_if.sv ----
`timescale 1ns/100ps
interface clk_sw_if;
  logic want_low;
  logic low_tick;
  logic use_low;
  logic busy;
  modport ctrl (output want_low, output low_tick, input use_low, input busy);
  modport sw (input want_low, input low_tick, output use_low, output busy);
endinterface : clk_sw_if

// ---- clock_switch_sync.sv ----
`timescale 1ns/100ps
module clock_switch_sync #(
  parameter int SYNC_TICKS = lpm_pkg::SYNC_TICKS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control side
  clk_sw_if.sw sw
);
  logic use_low_r;
  logic use_low_nxt;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;

  always_comb begin
    use_low_nxt = use_low_r;
    cnt_nxt = cnt_r;
    if (sw.want_low) begin
      use_low_nxt = 1'b1;
      cnt_nxt = 4'h0;
    end else if (use_low_r) begin
      // Stay on low clock until tick count aligns both clocks
      if (sw.low_tick) begin // [RULE18]
        if (cnt_r == 4'(SYNC_TICKS - 1)) begin
          use_low_nxt = 1'b0;
          cnt_nxt = 4'h0;
        end else begin
          cnt_nxt = cnt_r + 4'h1;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      use_low_r <= 1'b0;
      cnt_r <= 4'h0;
    end else begin
      use_low_r <= use_low_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign sw.use_low = use_low_r;
  assign sw.busy = use_low_r & ~sw.want_low;
endmodule : clock_switch_sync

// ---- low_power_mode_controller.sv ----
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/100ps
module low_power_mode_controller #(
  parameter int TB_SRC_N = 8
) (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // Register port
  input wire logic [lpm_pkg::ADDR_W-1:0] ADDR,
  input wire logic [lpm_pkg::DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [lpm_pkg::DATA_W-1:0] RDATA,
  // Pins and clock sources
  input wire logic RESET_PIN_N,
  input wire logic [TB_SRC_N-1:0] TB_SRC_CLKS,
  input wire logic LOW_CLK,
  // CPU side
  input wire logic [lpm_pkg::PC_W-1:0] INSTR_ADDR,
  input wire logic WDT_IRQ_PEND,
  input wire logic TB_IRQ_ACK,
  output logic [lpm_pkg::PC_W-1:0] RESUME_PC,
  output logic CPU_HOLD,
  output logic RESUME,
  output logic TB_IRQ_SERVICE,
  output logic CORE_RESET,
  // Clock gating and oscillators
  output logic PERIPH_CLK_EN,
  output logic TB_CLK_EN,
  output logic HIGH_OSC_EN,
  output logic LOW_OSC_EN,
  output logic SYS_CLK_LOW,
  output lpm_pkg::run_mode_t RUN_MODE
);
  typedef enum logic [1:0] {
    ST_RUN,
    ST_HALTED,
    ST_WAKE
  } lp_state_t;

  // Pin synchronisers, two stages each
  logic rst_pin_s1_r;
  logic rst_pin_s2_r;
  logic low_clk_s1_r;
  logic low_clk_s2_r;
  logic low_clk_d_r;
  logic [TB_SRC_N-1:0] tb_s1_r;
  logic [TB_SRC_N-1:0] tb_s2_r;
  logic tb_sel_d_r;

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      rst_pin_s1_r <= 1'b1;
      rst_pin_s2_r <= 1'b1;
      low_clk_s1_r <= 1'b0;
      low_clk_s2_r <= 1'b0;
    end else begin
      rst_pin_s1_r <= RESET_PIN_N;
      rst_pin_s2_r <= rst_pin_s1_r;
      low_clk_s1_r <= LOW_CLK;
      low_clk_s2_r <= low_clk_s1_r;
    end
  end

  genvar g;
  generate
    for (g = 0; g < TB_SRC_N; g = g + 1) begin : g_tb_sync
      always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
          tb_s1_r[g] <= 1'b0;
          tb_s2_r[g] <= 1'b0;
        end else begin
          tb_s1_r[g] <= TB_SRC_CLKS[g];
          tb_s2_r[g] <= tb_s1_r[g];
        end
      end
    end
  endgenerate

  // Registers
  logic [7:0] sys2_r;
  logic [7:0] sys2_nxt;
  logic [7:0] tbc_r;
  logic [7:0] tbc_nxt;
  logic mie_r;
  logic mie_nxt;
  logic tb_ie_r;
  logic tb_ie_nxt;
  logic tb_latch_r;
  logic tb_latch_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  lp_state_t state_r;
  lp_state_t state_nxt;
  logic wake_irq_r;
  logic wake_irq_nxt;
  logic [lpm_pkg::PC_W-1:0] resume_pc_r;
  logic [lpm_pkg::PC_W-1:0] resume_pc_nxt;
  logic resume_r;
  logic resume_nxt;
  logic tb_srv_r;
  logic tb_srv_nxt;
  logic low_clk_d_nxt;
  logic tb_sel_d_nxt;

  // Derived terms
  logic pin_reset;
  logic wr_sys2;
  logic wr_tbc;
  logic wr_irq;
  logic stop_req;
  logic tb_src;
  logic tb_fall;
  logic low_tick;
  logic wake_term;
  localparam int TB_SEL_W_L = lpm_pkg::TB_SEL_W;
  logic [TB_SEL_W_L-1:0] tb_sel;

  clk_sw_if csw ();

  clock_switch_sync #(
    .SYNC_TICKS(lpm_pkg::SYNC_TICKS)
  ) i_clock_switch_sync (
    .clk(REF_CLK),
    .rst(RST),
    .sw(csw.sw)
  );

  assign pin_reset = ~rst_pin_s2_r;
  assign wr_sys2 = WR & (ADDR == lpm_pkg::SYS_CTRL_TWO_OFS);
  assign wr_tbc = WR & (ADDR == lpm_pkg::TB_CTRL_OFS);
  assign wr_irq = WR & (ADDR == lpm_pkg::IRQ_CTRL_OFS);
  // Entry request needs only the stop bit written as 1
  assign stop_req = wr_sys2 & WDATA[lpm_pkg::STOP_BIT]; // [RULE5] [RULE10]
  assign tb_sel = tbc_r[lpm_pkg::TB_SEL_LSB +: TB_SEL_W_L];
  assign tb_src = tb_s2_r[tb_sel];
  // Falling edge of selected source, taken straight from synced level
  assign tb_fall = tb_sel_d_r & ~tb_src; // [RULE12]
  assign low_tick = low_clk_d_r & ~low_clk_s2_r;
  assign wake_term = mie_r & tb_ie_r & tbc_r[lpm_pkg::TB_EN_BIT];

  always_comb begin
    sys2_nxt = sys2_r;
    tbc_nxt = tbc_r;
    mie_nxt = mie_r;
    tb_ie_nxt = tb_ie_r;
    tb_latch_nxt = tb_latch_r;
    state_nxt = state_r;
    wake_irq_nxt = wake_irq_r;
    resume_pc_nxt = resume_pc_r;
    resume_nxt = 1'b0;
    tb_srv_nxt = 1'b0;
    low_clk_d_nxt = low_clk_s2_r;
    tb_sel_d_nxt = tb_src;
    if (TB_IRQ_ACK) begin
      tb_latch_nxt = 1'b0;
    end
    if (wr_tbc) begin
      tbc_nxt = WDATA & 8'h0F;
    end
    if (wr_irq) begin
      mie_nxt = WDATA[lpm_pkg::MIE_BIT];
      tb_ie_nxt = WDATA[lpm_pkg::TB_IE_BIT];
      if (!WDATA[lpm_pkg::TB_LATCH_BIT]) begin
        tb_latch_nxt = 1'b0;
      end
    end
    case (state_r)
      ST_RUN: begin
        if (wr_sys2) begin
          sys2_nxt[lpm_pkg::HIGH_OSC_EN_BIT] =
            WDATA[lpm_pkg::HIGH_OSC_EN_BIT];
          sys2_nxt[lpm_pkg::LOW_OSC_EN_BIT] =
            WDATA[lpm_pkg::LOW_OSC_EN_BIT];
          sys2_nxt[lpm_pkg::SYS_CLK_SEL_BIT] =
            WDATA[lpm_pkg::SYS_CLK_SEL_BIT];
        end
        if (stop_req) begin
          if (WDT_IRQ_PEND) begin
            // Watchdog wins, no entry
            sys2_nxt[lpm_pkg::STOP_BIT] = 1'b0; // [RULE13]
          end else begin
            sys2_nxt[lpm_pkg::STOP_BIT] = 1'b1; // [RULE5]
            state_nxt = ST_HALTED;
            resume_pc_nxt = INSTR_ADDR + lpm_pkg::PC_STEP; // [RULE3]
            if (tbc_nxt[lpm_pkg::TB_EN_BIT]) begin
              tb_latch_nxt = 1'b1; // [RULE9]
            end
          end
        end
      end
      ST_HALTED: begin
        // System control two writes ignored while core held
        if (tb_fall) begin // [RULE10] [RULE12]
          state_nxt = ST_WAKE;
          wake_irq_nxt = wake_term;
        end
      end
      ST_WAKE: begin
        // Clear stop bit; clock bits untouched so mode returns
        sys2_nxt[lpm_pkg::STOP_BIT] = 1'b0; // [RULE8]
        state_nxt = ST_RUN;
        if (wake_irq_r) begin
          tb_srv_nxt = 1'b1; // [RULE7]
        end else begin
          resume_nxt = 1'b1; // [RULE6]
        end
        wake_irq_nxt = 1'b0;
      end
      default: begin
        state_nxt = ST_RUN;
      end
    endcase
    if (pin_reset) begin
      // Reset pin ends any mode, restart in single clock run
      sys2_nxt = lpm_pkg::SYS_CTRL_TWO_RST; // [RULE11]
      tbc_nxt = lpm_pkg::TB_CTRL_RST;
      mie_nxt = 1'b0;
      tb_ie_nxt = 1'b0;
      tb_latch_nxt = 1'b0;
      state_nxt = ST_RUN;
      wake_irq_nxt = 1'b0;
      resume_nxt = 1'b0;
      tb_srv_nxt = 1'b0;
    end
  end

  always_comb begin
    rdata_nxt = 8'h00;
    if (RD) begin
      case (ADDR)
        lpm_pkg::SYS_CTRL_TWO_OFS: rdata_nxt = sys2_r;
        lpm_pkg::TB_CTRL_OFS: rdata_nxt = tbc_r;
        lpm_pkg::STATUS_OFS: begin
          rdata_nxt = {3'h0, csw.use_low, csw.busy, RUN_MODE,
            (state_r != ST_RUN)};
        end
        lpm_pkg::IRQ_CTRL_OFS: begin
          rdata_nxt = {5'h00, tb_latch_r, tb_ie_r, mie_r};
        end
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      sys2_r <= lpm_pkg::SYS_CTRL_TWO_RST;
      tbc_r <= lpm_pkg::TB_CTRL_RST;
      mie_r <= 1'b0;
      tb_ie_r <= 1'b0;
      tb_latch_r <= 1'b0;
      rdata_r <= 8'h00;
      state_r <= ST_RUN;
      wake_irq_r <= 1'b0;
      resume_pc_r <= 16'h0000;
      resume_r <= 1'b0;
      tb_srv_r <= 1'b0;
      low_clk_d_r <= 1'b0;
      tb_sel_d_r <= 1'b0;
    end else begin
      sys2_r <= sys2_nxt;
      tbc_r <= tbc_nxt;
      mie_r <= mie_nxt;
      tb_ie_r <= tb_ie_nxt;
      tb_latch_r <= tb_latch_nxt;
      rdata_r <= rdata_nxt;
      state_r <= state_nxt;
      wake_irq_r <= wake_irq_nxt;
      resume_pc_r <= resume_pc_nxt;
      resume_r <= resume_nxt;
      tb_srv_r <= tb_srv_nxt;
      low_clk_d_r <= low_clk_d_nxt;
      tb_sel_d_r <= tb_sel_d_nxt;
    end
  end

  // Clock switch: request on select, sync on release of select
  assign csw.want_low = sys2_r[lpm_pkg::SYS_CLK_SEL_BIT];
  assign csw.low_tick = low_tick; // [RULE18]

  always_comb begin
    if (!sys2_r[lpm_pkg::HIGH_OSC_EN_BIT] &&
        !sys2_r[lpm_pkg::LOW_OSC_EN_BIT]) begin
      RUN_MODE = lpm_pkg::SINGLE_CLOCK_RUN;
    end else if (!sys2_r[lpm_pkg::LOW_OSC_EN_BIT]) begin
      RUN_MODE = lpm_pkg::SINGLE_CLOCK_RUN;
    end else if (!csw.use_low) begin
      RUN_MODE = lpm_pkg::DUAL_CLOCK_FAST_RUN;
    end else if (sys2_r[lpm_pkg::HIGH_OSC_EN_BIT]) begin
      RUN_MODE = lpm_pkg::SLOW_RUN_FAST_OSC_ON;
    end else begin
      RUN_MODE = lpm_pkg::SLOW_RUN_FAST_OSC_OFF;
    end
  end

  assign RDATA = rdata_r;
  assign RESUME_PC = resume_pc_r;
  // Core stalled: memory, registers and latches keep their values
  assign CPU_HOLD = (state_r != ST_RUN); // [RULE2]
  assign PERIPH_CLK_EN = (state_r == ST_RUN); // [RULE1]
  assign TB_CLK_EN = 1'b1; // [RULE1]
  assign RESUME = resume_r;
  assign TB_IRQ_SERVICE = tb_srv_r;
  assign CORE_RESET = pin_reset; // [RULE11]
  assign HIGH_OSC_EN = sys2_r[lpm_pkg::HIGH_OSC_EN_BIT];
  assign LOW_OSC_EN = sys2_r[lpm_pkg::LOW_OSC_EN_BIT];
  assign SYS_CLK_LOW = csw.use_low;
endmodule : low_power_mode_controller

// ---- low_power_mode_controller_sva.sv ----
`timescale 1ns/100ps
module low_power_mode_controller_sva (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // Register port and pins
  input wire logic [lpm_pkg::ADDR_W-1:0] ADDR,
  input wire logic [lpm_pkg::DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RESET_PIN_N,
  // CPU side
  input wire logic [lpm_pkg::PC_W-1:0] INSTR_ADDR,
  input wire logic WDT_IRQ_PEND,
  input wire logic [lpm_pkg::PC_W-1:0] RESUME_PC,
  input wire logic CPU_HOLD,
  input wire logic RESUME,
  input wire logic TB_IRQ_SERVICE,
  input wire logic CORE_RESET,
  // Clock gating
  input wire logic PERIPH_CLK_EN,
  input wire logic TB_CLK_EN,
  input lpm_pkg::run_mode_t RUN_MODE
);
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RST);
  wire stop_wr = WR && ADDR == lpm_pkg::SYS_CTRL_TWO_OFS &&
      WDATA[lpm_pkg::STOP_BIT] &&
      !CPU_HOLD && !CORE_RESET && RESET_PIN_N;
  property p_gate;
    CPU_HOLD |-> !PERIPH_CLK_EN && TB_CLK_EN;
  endproperty
  a_gate: assert property (p_gate)
    else $error("peripheral clock not gated while halted");
  property p_enter;
    stop_wr && !WDT_IRQ_PEND |=> CPU_HOLD;
  endproperty
  a_enter: assert property (p_enter)
    else $error("stop write did not halt");
  property p_pc;
    stop_wr && !WDT_IRQ_PEND |=>
      RESUME_PC == 16'($past(INSTR_ADDR) + 16'h0002);
  endproperty
  a_pc: assert property (p_pc)
    else $error("resume address wrong");
  property p_wdt;
    stop_wr && WDT_IRQ_PEND |=> !CPU_HOLD;
  endproperty
  a_wdt: assert property (p_wdt)
    else $error("halted despite pending watchdog interrupt");
  property p_hold;
    CPU_HOLD && $past(CPU_HOLD) |-> $stable(RESUME_PC);
  endproperty
  a_hold: assert property (p_hold)
    else $error("resume address changed while halted");
  property p_wake;
    $fell(CPU_HOLD) && !CORE_RESET |-> RESUME || TB_IRQ_SERVICE;
  endproperty
  a_wake: assert property (p_wake)
    else $error("release without resume or service pulse");
  property p_pulse;
    RESUME || TB_IRQ_SERVICE |-> !(RESUME && TB_IRQ_SERVICE) ##1
      !RESUME && !TB_IRQ_SERVICE;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("release pulses overlap or too long");
  property p_pin;
    !RESET_PIN_N [*4] |-> CORE_RESET && !CPU_HOLD &&
      RUN_MODE == lpm_pkg::SINGLE_CLOCK_RUN;
  endproperty
  a_pin: assert property (p_pin)
    else $error("reset pin did not restart single clock run");
endmodule : low_power_mode_controller_sva

bind low_power_mode_controller low_power_mode_controller_sva
    i_low_power_mode_controller_sva (
  .REF_CLK(REF_CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
  .RESET_PIN_N(RESET_PIN_N), .INSTR_ADDR(INSTR_ADDR),
  .WDT_IRQ_PEND(WDT_IRQ_PEND), .RESUME_PC(RESUME_PC), .CPU_HOLD(CPU_HOLD),
  .RESUME(RESUME), .TB_IRQ_SERVICE(TB_IRQ_SERVICE), .CORE_RESET(CORE_RESET),
  .PERIPH_CLK_EN(PERIPH_CLK_EN), .TB_CLK_EN(TB_CLK_EN), .RUN_MODE(RUN_MODE)
);

// ---- low_power_mode_controller_bench.sv ----
`timescale 1ns/100ps
module low_power_mode_controller_bench;
  logic REF_CLK = 1'h0;
  logic RST = 1'h1;
  logic [1:0] ADDR = 2'h0;
  logic [7:0] WDATA = 8'h00;
  logic WR = 1'h0;
  logic RD = 1'h0;
  logic RESET_PIN_N = 1'h1;
  logic [7:0] TB_SRC_CLKS = 8'hFF;
  logic LOW_CLK = 1'h0;
  logic [15:0] INSTR_ADDR = 16'h0000;
  logic WDT_IRQ_PEND = 1'h0;
  logic TB_IRQ_ACK = 1'h0;
  logic [7:0] RDATA;
  logic [15:0] RESUME_PC;
  logic CPU_HOLD, RESUME, TB_IRQ_SERVICE, CORE_RESET;
  logic PERIPH_CLK_EN, TB_CLK_EN, HIGH_OSC_EN, LOW_OSC_EN, SYS_CLK_LOW;
  lpm_pkg::run_mode_t RUN_MODE;
  int errors = 0;
  int n_tests = 0;
  int cyc = 0;

  always #5 REF_CLK = ~REF_CLK;

  low_power_mode_controller i_low_power_mode_controller (
    .REF_CLK(REF_CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .RESET_PIN_N(RESET_PIN_N),
    .TB_SRC_CLKS(TB_SRC_CLKS), .LOW_CLK(LOW_CLK), .INSTR_ADDR(INSTR_ADDR),
    .WDT_IRQ_PEND(WDT_IRQ_PEND), .TB_IRQ_ACK(TB_IRQ_ACK),
    .RESUME_PC(RESUME_PC), .CPU_HOLD(CPU_HOLD), .RESUME(RESUME),
    .TB_IRQ_SERVICE(TB_IRQ_SERVICE), .CORE_RESET(CORE_RESET),
    .PERIPH_CLK_EN(PERIPH_CLK_EN), .TB_CLK_EN(TB_CLK_EN),
    .HIGH_OSC_EN(HIGH_OSC_EN), .LOW_OSC_EN(LOW_OSC_EN),
    .SYS_CLK_LOW(SYS_CLK_LOW), .RUN_MODE(RUN_MODE)
  );

  task automatic check(input string what, input logic [15:0] got,
      input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic tick(input int n);
    repeat (n) @(posedge REF_CLK);
    #1;
  endtask : tick

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge REF_CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'h1;
    @(posedge REF_CLK);
    WR <= 1'h0;
    #1;
  endtask : wr

  task automatic rd(input logic [1:0] a, input logic [7:0] exp,
      input string what);
    @(posedge REF_CLK);
    ADDR <= a;
    RD <= 1'h1;
    @(posedge REF_CLK);
    RD <= 1'h0;
    #1;
    check(what, RDATA, exp);
  endtask : rd

  task automatic low_ticks(input int n);
    repeat (n) begin
      @(posedge REF_CLK);
      LOW_CLK <= 1'h1;
      repeat (4) @(posedge REF_CLK);
      LOW_CLK <= 1'h0;
      repeat (4) @(posedge REF_CLK);
    end
    #1;
  endtask : low_ticks

  // Halt, ignore an unselected source, wake on source 3
  task automatic nap(input logic [7:0] tbc, irq, exp_irq, input logic svc,
      input logic [15:0] pc);
    int k;
    wr(2'h1, tbc);
    wr(2'h3, irq);
    @(posedge REF_CLK);
    INSTR_ADDR <= pc;
    wr(2'h0, 8'h84);
    check("hold", CPU_HOLD, 1'h1);
    check("clk gates", {PERIPH_CLK_EN, TB_CLK_EN}, 2'h1);
    check("resume pc", RESUME_PC, pc + 16'h0002);
    rd(2'h3, exp_irq, "irq latch");
    rd(2'h2, 8'h01, "halted status");
    @(posedge REF_CLK);
    TB_SRC_CLKS <= 8'hDF;
    tick(8);
    check("still held", CPU_HOLD, 1'h1);
    @(posedge REF_CLK);
    TB_SRC_CLKS <= 8'hD7;
    for (k = 0; k < 20; k++) begin
      tick(1);
      if (RESUME === 1'h1 || TB_IRQ_SERVICE === 1'h1) break;
    end
    check("release", {RESUME, TB_IRQ_SERVICE}, {!svc, svc});
    check("run again", {CPU_HOLD, RUN_MODE}, 3'h0);
    rd(2'h0, 8'h80, "stop bit cleared");
    @(posedge REF_CLK);
    TB_IRQ_ACK <= 1'h1;
    TB_SRC_CLKS <= 8'hFF;
    @(posedge REF_CLK);
    TB_IRQ_ACK <= 1'h0;
    rd(2'h3, irq, "irq after ack");
    $display("test sleep cycle done");
  endtask : nap

  always @(posedge REF_CLK) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      tally_and_finish;
    end
  end

  initial begin
    repeat (2) @(posedge REF_CLK);
    RST <= 1'h0;
    rd(2'h0, 8'h80, "sys ctrl");
    rd(2'h1, 8'h00, "tb ctrl");
    rd(2'h2, 8'h00, "status");
    rd(2'h3, 8'h00, "irq ctrl");
    $display("test reset values done");
    nap(8'h0B, 8'h00, 8'h04, 1'h0, 16'h1234);
    nap(8'h0B, 8'h03, 8'h07, 1'h1, 16'h2000);
    nap(8'h03, 8'h03, 8'h03, 1'h0, 16'hFFFE);
    @(posedge REF_CLK);
    WDT_IRQ_PEND <= 1'h1;
    wr(2'h0, 8'h84);
    check("wdt hold", CPU_HOLD, 1'h0);
    rd(2'h0, 8'h80, "wdt stop bit");
    @(posedge REF_CLK);
    WDT_IRQ_PEND <= 1'h0;
    $display("test watchdog pending done");
    wr(2'h0, 8'hC0);
    wr(2'h0, 8'hE0);
    tick(1);
    check("on low clk", SYS_CLK_LOW, 1'h1);
    wr(2'h0, 8'h60);
    rd(2'h2, 8'h16, "slow status");
    wr(2'h0, 8'hE0);
    check("slow osc on", RUN_MODE, lpm_pkg::SLOW_RUN_FAST_OSC_ON);
    wr(2'h0, 8'hC0);
    tick(10);
    check("sync wait", SYS_CLK_LOW, 1'h1);
    low_ticks(3);
    check("switched", SYS_CLK_LOW, 1'h0);
    check("fast mode", RUN_MODE, lpm_pkg::DUAL_CLOCK_FAST_RUN);
    $display("test clock switch done");
    wr(2'h1, 8'h0B);
    wr(2'h3, 8'h00);
    wr(2'h0, 8'hC4);
    check("dual hold", CPU_HOLD, 1'h1);
    @(posedge REF_CLK);
    RESET_PIN_N <= 1'h0;
    tick(4);
    check("pin reset", {CORE_RESET, CPU_HOLD, RUN_MODE}, 4'h8);
    @(posedge REF_CLK);
    RESET_PIN_N <= 1'h1;
    tick(4);
    rd(2'h0, 8'h80, "sys after pin");
    rd(2'h1, 8'h00, "tb after pin");
    $display("test reset pin done");
    tally_and_finish;
  end
endmodule : low_power_mode_controller_bench
